/* File: design/dcrc_top.v */
// dma channel request control: set/clear registers and request qualification
//
// Notes on behaviour
// R1 - a one written to a software trigger bit raises a request for that channel, a zero none.
// R2 - bit n of every per-channel set or clear register acts on channel n only, 0 to 31.
// R3 - a one written to the burst-only set register stops single requests of that channel.
// R4 - reading burst-only set gives 0 where single requests are taken and 1 where not.
// R5 - zeros written to any set or clear register leave the channel state alone.
// R6 - a one written to the burst-only clear register lets single requests in again.
// R7 - the engine clears a burst-only bit when fewer than 2^R transfers remain near the end.
// R8 - in peripheral scatter-gather with next-burst set, the bit is set after the alt transfer.
// R9 - software does not set burst-only on short transfers that use no burst requests.
// R10 - a one written to the mask set register makes that channel's requests ignored.
// R11 - reading mask set gives 0 where requests are taken and 1 where masked.
// R12 - a one written to the mask clear register lets that channel's requests in again.
// R13 - channel enable is set by writing one, reads back, and drops at cycle end, stop or error.
// R14 - the master enable bit, 0 off and 1 on, gates all dma operation.
// R15 - requests reach arbitration only when enabled, unmasked, and singles not burst-only.
// R16 - a software trigger is an unmasked one-cycle burst request and is not stored.
`timescale 1ns/100ps
`default_nettype none
`include "dcrc_consts.vh"

module dcrc_top
(
	// clock, reset, clock enable
	input  wire        i_mclk,
	input  wire        i_arst_n,
	input  wire        i_ce,
	// word-wide peripheral register bus
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output wire [31:0] o_prdata,
	output wire        o_pslverr,
	// peripheral requests, one bit per channel
	input  wire [31:0] i_periph_burst_req,
	input  wire [31:0] i_periph_single_req,
	// events from the transfer engine, one bit per channel
	input  wire [31:0] i_burst_drop_evt,
	input  wire [31:0] i_burst_raise_evt,
	input  wire [31:0] i_chan_off_evt,
	// qualified requests toward arbitration
	output wire [31:0] o_burst_req,
	output wire [31:0] o_single_req,
	// state views for the engine
	output wire        o_master_en,
	output wire [31:0] o_chan_on,
	output wire [31:0] o_burst_only,
	output wire [31:0] o_req_mask
);

	////////////////////////////////////////////////////////////////////////////
	// bus phase decode

	wire        setup_ph;
	wire        access_ph;
	wire        wr_acc;
	reg         hit_status;
	reg         hit_cfg;
	reg         hit_swtrig;
	reg         hit_burst_set;
	reg         hit_burst_clr;
	reg         hit_mask_set;
	reg         hit_mask_clr;
	reg         hit_chon_set;
	reg         hit_chon_clr;
	reg         hit_any;

	// zero wait states: every access completes in its first access cycle
	assign setup_ph  = i_psel & ~i_penable;
	assign access_ph = i_psel & i_penable;
	assign wr_acc    = access_ph & i_pwrite;
	assign o_pready  = 1'b1;

	// address decode, word offsets only; low address bits must be zero
	always @*
	begin
		hit_status    = 1'b0;
		hit_cfg       = 1'b0;
		hit_swtrig    = 1'b0;
		hit_burst_set = 1'b0;
		hit_burst_clr = 1'b0;
		hit_mask_set  = 1'b0;
		hit_mask_clr  = 1'b0;
		hit_chon_set  = 1'b0;
		hit_chon_clr  = 1'b0;
		if (i_paddr == `DCRC_OFS_STATUS)
			hit_status = 1'b1;
		else if (i_paddr == `DCRC_OFS_CFG)
			hit_cfg = 1'b1;
		else if (i_paddr == `DCRC_OFS_SWTRIG)
			hit_swtrig = 1'b1;
		else if (i_paddr == `DCRC_OFS_BURST_SET)
			hit_burst_set = 1'b1;
		else if (i_paddr == `DCRC_OFS_BURST_CLR)
			hit_burst_clr = 1'b1;
		else if (i_paddr == `DCRC_OFS_MASK_SET)
			hit_mask_set = 1'b1;
		else if (i_paddr == `DCRC_OFS_MASK_CLR)
			hit_mask_clr = 1'b1;
		else if (i_paddr == `DCRC_OFS_CHON_SET)
			hit_chon_set = 1'b1;
		else if (i_paddr == `DCRC_OFS_CHON_CLR)
			hit_chon_clr = 1'b1;
		hit_any = hit_status | hit_cfg | hit_swtrig | hit_burst_set | hit_burst_clr |
			hit_mask_set | hit_mask_clr | hit_chon_set | hit_chon_clr;
	end

	////////////////////////////////////////////////////////////////////////////
	// write strobes: a written zero turns into no strobe at all

	wire [31:0] wr_data;
	wire [31:0] swtrig_bits;
	wire [31:0] burst_set_bits;
	wire [31:0] burst_clr_bits;
	wire [31:0] mask_set_bits;
	wire [31:0] mask_clr_bits;
	wire [31:0] chon_set_bits;
	wire [31:0] chon_clr_bits;

	// write data is masked per register, so bit n strobes only channel n
	assign wr_data        = wr_acc ? i_pwdata : `DCRC_RST_WORD;                        // R2
	assign swtrig_bits    = hit_swtrig    ? wr_data : `DCRC_RST_WORD;                  // R1
	assign burst_set_bits = hit_burst_set ? wr_data : `DCRC_RST_WORD;                  // R3 R5
	assign burst_clr_bits = hit_burst_clr ? wr_data : `DCRC_RST_WORD;                  // R6 R5
	assign mask_set_bits  = hit_mask_set  ? wr_data : `DCRC_RST_WORD;                  // R10 R5
	assign mask_clr_bits  = hit_mask_clr  ? wr_data : `DCRC_RST_WORD;                  // R12 R5
	assign chon_set_bits  = hit_chon_set  ? wr_data : `DCRC_RST_WORD;                  // R13 R5
	assign chon_clr_bits  = hit_chon_clr  ? wr_data : `DCRC_RST_WORD;                  // R5

	////////////////////////////////////////////////////////////////////////////
	// per-channel state vectors

	wire [31:0] burst_only;
	wire [31:0] req_mask;
	wire [31:0] chan_on;

	// burst-only: engine drops it near the end, raises it after scatter-gather alt
	// software should keep it clear on short non-burst transfers; nothing here checks
	dcrc_setclr_bits
	#(
		.RST_VAL (`DCRC_RST_BURST)
	)
	u_burst_only
	(
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_ce     (i_ce),
		.i_sw_set (burst_set_bits),                                                 // R3
		.i_sw_clr (burst_clr_bits),                                                 // R6
		.i_hw_set (i_burst_raise_evt),                                              // R8
		.i_hw_clr (i_burst_drop_evt),                                               // R7
		.o_state  (burst_only)
	);

	// request mask: software only
	dcrc_setclr_bits
	#(
		.RST_VAL (`DCRC_RST_MASK)
	)
	u_req_mask
	(
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_ce     (i_ce),
		.i_sw_set (mask_set_bits),                                                  // R10
		.i_sw_clr (mask_clr_bits),                                                  // R12
		.i_hw_set (`DCRC_RST_WORD),
		.i_hw_clr (`DCRC_RST_WORD),
		.o_state  (req_mask)
	);

	// channel enable: dropped by cycle end, stop word or bus error from the engine
	dcrc_setclr_bits
	#(
		.RST_VAL (`DCRC_RST_CHON)
	)
	u_chan_on
	(
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_ce     (i_ce),
		.i_sw_set (chon_set_bits),                                                  // R13
		.i_sw_clr (chon_clr_bits),
		.i_hw_set (`DCRC_RST_WORD),
		.i_hw_clr (i_chan_off_evt),                                                 // R13
		.o_state  (chan_on)
	);

	////////////////////////////////////////////////////////////////////////////
	// master enable

	reg master_en_ff;

	// written through the configuration word, bit 0 only
	always @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			master_en_ff <= `DCRC_RST_MASTER;
		else if (i_ce && wr_acc && hit_cfg)
			master_en_ff <= i_pwdata[`DCRC_MASTER_EN_BIT];                          // R14
	end

	////////////////////////////////////////////////////////////////////////////
	// request qualification

	reg  [31:0] burst_req_ff;
	reg  [31:0] single_req_ff;
	wire [31:0] gate;
	wire [31:0] nxt_burst_req;
	wire [31:0] nxt_single_req;

	// master and channel enable gate every source
	assign gate = {32{master_en_ff}} & chan_on;                                     // R14 R15

	// software trigger bypasses the mask and lives for one cycle only
	assign nxt_burst_req  = gate & ((i_periph_burst_req & ~req_mask) | swtrig_bits); // R15 R16

	// singles need no mask and no burst-only state
	assign nxt_single_req = gate & i_periph_single_req & ~req_mask & ~burst_only;   // R3 R15

	// registered so arbitration sees clean flop outputs, one cycle after the cause
	always @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			burst_req_ff  <= `DCRC_RST_WORD;
			single_req_ff <= `DCRC_RST_WORD;
		end
		else if (i_ce)
		begin
			burst_req_ff  <= nxt_burst_req;                                         // R16
			single_req_ff <= nxt_single_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path and error answer

	reg  [31:0] prdata_ff;
	reg         pslverr_ff;
	reg  [31:0] nxt_prdata;

	// write-only words read as zero; the trigger keeps no state to show
	always @*
	begin
		nxt_prdata = `DCRC_RST_WORD;
		if (hit_status)
			nxt_prdata = `DCRC_STATUS_FIXED | {31'h0000_0000, master_en_ff};
		else if (hit_burst_set)
			nxt_prdata = burst_only;                                                // R4
		else if (hit_mask_set)
			nxt_prdata = req_mask;                                                  // R11
		else if (hit_chon_set)
			nxt_prdata = chan_on;                                                   // R13
	end

	// sampled in the setup cycle so data and error stand through the access cycle
	always @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			prdata_ff  <= `DCRC_RST_WORD;
			pslverr_ff <= 1'b0;
		end
		else if (i_ce)
		begin
			if (setup_ph)
			begin
				prdata_ff  <= i_pwrite ? `DCRC_RST_WORD : nxt_prdata;
				pslverr_ff <= ~hit_any;
			end
			else if (access_ph)
			begin
				prdata_ff  <= prdata_ff;
				pslverr_ff <= pslverr_ff;
			end
			else
			begin
				prdata_ff  <= `DCRC_RST_WORD;
				pslverr_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_prdata     = prdata_ff;
	assign o_pslverr    = pslverr_ff & access_ph;
	assign o_burst_req  = burst_req_ff;
	assign o_single_req = single_req_ff;
	assign o_master_en  = master_en_ff;
	assign o_chan_on    = chan_on;
	assign o_burst_only = burst_only;
	assign o_req_mask   = req_mask;

endmodule

`default_nettype wire

/* File: common/dcrc_consts.vh */
// constants for the dma channel request control block
`ifndef DCRC_CONSTS_VH
`define DCRC_CONSTS_VH

// channel count and register width
`define DCRC_NCH            32
`define DCRC_DW             32
`define DCRC_AW             12

// register byte offsets, word aligned
`define DCRC_OFS_STATUS     12'h000
`define DCRC_OFS_CFG        12'h004
`define DCRC_OFS_SWTRIG     12'h014
`define DCRC_OFS_BURST_SET  12'h018
`define DCRC_OFS_BURST_CLR  12'h01C
`define DCRC_OFS_MASK_SET   12'h020
`define DCRC_OFS_MASK_CLR   12'h024
`define DCRC_OFS_CHON_SET   12'h028
`define DCRC_OFS_CHON_CLR   12'h02C

// field positions
`define DCRC_MASTER_EN_BIT  0

// fixed bits of the status word (bit 28 and bits 20-16 read as one)
`define DCRC_STATUS_FIXED   32'h101F_0000

// reset values
`define DCRC_RST_BURST      32'h0000_0000
`define DCRC_RST_MASK       32'h0000_0000
`define DCRC_RST_CHON       32'h0000_0000
`define DCRC_RST_MASTER     1'b0
`define DCRC_RST_WORD       32'h0000_0000

`endif

/* File: design/dcrc_setclr_bits.v */
// one per-channel set/clear state vector with software and hardware sources
`timescale 1ns/100ps
`default_nettype none

module dcrc_setclr_bits
#(
	parameter [31:0] RST_VAL = 32'h0000_0000
)
(
	// clock, reset, enable
	input  wire        i_mclk,
	input  wire        i_arst_n,
	input  wire        i_ce,
	// software set/clear strobes, one bit per channel
	input  wire [31:0] i_sw_set,
	input  wire [31:0] i_sw_clr,
	// hardware set/clear events, one bit per channel
	input  wire [31:0] i_hw_set,
	input  wire [31:0] i_hw_clr,
	// current state
	output wire [31:0] o_state
);

	reg  [31:0] state_ff;
	wire [31:0] nxt_state;

	// any set beats any clear in the same cycle, so no set event is lost
	assign nxt_state = (state_ff & ~(i_sw_clr | i_hw_clr)) | i_sw_set | i_hw_set;

	// state holds while clock enable is low
	always @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state_ff <= RST_VAL;
		else if (i_ce)
			state_ff <= nxt_state;
	end

	assign o_state = state_ff;

endmodule

`default_nettype wire

/* File: bench/dcrc_checker.sv */
// assertion checker for the channel request control block
`timescale 1ns/100ps
`default_nettype none

module dcrc_checker
(
	// clock, reset, enable
	input wire        i_mclk,
	input wire        i_arst_n,
	input wire        i_ce,
	// register bus
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	// requests and engine events
	input wire [31:0] i_periph_single_req,
	input wire [31:0] i_burst_drop_evt,
	input wire [31:0] i_burst_raise_evt,
	input wire [31:0] o_burst_req,
	input wire [31:0] o_single_req,
	// state views
	input wire        o_master_en,
	input wire [31:0] o_chan_on,
	input wire [31:0] o_burst_only,
	input wire [31:0] o_req_mask
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	// write taken at the end of this cycle; engine idle so sw owns the state
	wire wr = i_psel && i_penable && i_pwrite && i_ce;
	wire quiet = (i_burst_drop_evt | i_burst_raise_evt) == 32'h0;
	////////////////////////////////////////////////////////////////////////
	a_trig_pulse: assert property (wr && i_paddr == 12'h014 && o_master_en |=>
		(o_burst_req & $past(i_pwdata) & $past(o_chan_on)) == ($past(i_pwdata) & $past(o_chan_on)))
		else $error("trigger gave no burst request");
	a_burst_set: assert property (wr && i_paddr == 12'h018 |=>
		(o_burst_only & $past(i_pwdata)) == $past(i_pwdata)) else $error("burst-only not set");
	a_burst_clr: assert property (wr && i_paddr == 12'h01C && quiet |=>
		(o_burst_only & $past(i_pwdata)) == 32'h0) else $error("burst-only not cleared");
	a_zero_keep: assert property (wr && i_pwdata == 32'h0 && quiet |=>
		$stable(o_burst_only) && $stable(o_req_mask)) else $error("zero write changed state");
	a_mask_set: assert property (wr && i_paddr == 12'h020 |=>
		(o_req_mask & $past(i_pwdata)) == $past(i_pwdata)) else $error("mask not set");
	a_mask_clr: assert property (wr && i_paddr == 12'h024 |=>
		(o_req_mask & $past(i_pwdata)) == 32'h0) else $error("mask not cleared");
	a_mask_read: assert property (i_psel && i_penable && !i_pwrite && i_paddr == 12'h020 |->
		o_prdata == o_req_mask) else $error("mask read mismatch");
	a_single_qual: assert property (i_ce |=> o_single_req == ({32{$past(o_master_en)}} &
		$past(o_chan_on) & $past(i_periph_single_req) & ~$past(o_req_mask) &
		~$past(o_burst_only))) else $error("single request qualification wrong");
	a_no_master: assert property (i_ce && !o_master_en |=>
		o_burst_req == 32'h0) else $error("burst request while master off");
endmodule

`default_nettype wire

/* File: bench/dcrc_periph_model.sv */
// peripheral side: drives request levels as the bench commands
`timescale 1ns/100ps
`default_nettype none

module dcrc_periph_model
(
	// clock and reset
	input  wire        i_mclk,
	input  wire        i_arst_n,
	// wanted request levels
	input  wire [31:0] i_want_burst,
	input  wire [31:0] i_want_single,
	// request lines toward the block
	output logic [31:0] o_burst_req,
	output logic [31:0] o_single_req
);
	// launched just after an edge, quiet in reset
	always @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_burst_req <= 32'h0;
			o_single_req <= 32'h0;
		end
		else
		begin
			o_burst_req <= i_want_burst;
			o_single_req <= i_want_single;
		end
	end
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the channel request control block
`timescale 1ns/100ps
`default_nettype none

module testbench;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         psel = 1'b0;
	reg         pen = 1'b0;
	reg         pwr = 1'b0;
	reg  [11:0] addr = 12'h0;
	reg  [31:0] wdat = 32'h0;
	reg  [31:0] wb = 32'h0;
	reg  [31:0] ws = 32'h0;
	reg  [31:0] drop = 32'h0;
	reg  [31:0] rais = 32'h0;
	reg  [31:0] off = 32'h0;
	reg  [31:0] rd;
	reg         rerr;
	reg         ce = 1'b1;
	wire        rdy, err, men;
	wire [31:0] rdat, pb, ps, breq, sreq, con, bon, msk;
	int         num_errors = 0;
	int         comparisons = 0;
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	dcrc_periph_model u_per (.i_mclk(clk), .i_arst_n(rst_n), .i_want_burst(wb),
		.i_want_single(ws), .o_burst_req(pb), .o_single_req(ps));
	dcrc_top dut (.i_mclk(clk), .i_arst_n(rst_n), .i_ce(ce), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
		.o_pready(rdy), .o_prdata(rdat), .o_pslverr(err), .i_periph_burst_req(pb),
		.i_periph_single_req(ps), .i_burst_drop_evt(drop), .i_burst_raise_evt(rais),
		.i_chan_off_evt(off), .o_burst_req(breq), .o_single_req(sreq),
		.o_master_en(men), .o_chan_on(con), .o_burst_only(bon), .o_req_mask(msk));
	////////////////////////////////////////////////////////////////////////
	task close_out;
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	// one transfer; request held until the edge where ready is seen
	task xfer(input w, input [11:0] a, input [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			n++;
		end
		rd = rdat;
		rerr = err;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n == 8)
		begin
			num_errors++;
			close_out;
		end
	endtask
	task rchk(input string nm, input [11:0] a, input [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rchk("status", 12'h000, 32'h101F_0000);
		rchk("burst", 12'h018, 32'h0000_0000);
		rchk("mask", 12'h020, 32'h0000_0000);
		rchk("chon", 12'h028, 32'h0000_0000);
		xfer(1'b1, 12'h004, 32'h0000_0001);
		rchk("status", 12'h000, 32'h101F_0001);
		xfer(1'b1, 12'h028, 32'hFFFF_FFFF);
		rchk("chon", 12'h028, 32'hFFFF_FFFF);
		// transfers here are long, so burst-only is safe to set
		xfer(1'b1, 12'h018, 32'hA5A5_0F01);
		rchk("burst", 12'h018, 32'hA5A5_0F01);
		xfer(1'b1, 12'h018, 32'h0000_0000);
		xfer(1'b1, 12'h01C, 32'h0000_0F00);
		rchk("burst", 12'h018, 32'hA5A5_0001);
		rchk("bclr", 12'h01C, 32'h0000_0000);
		xfer(1'b1, 12'h020, 32'h8000_0003);
		xfer(1'b1, 12'h024, 32'h8000_0000);
		rchk("mask", 12'h020, 32'h0000_0003);
		wb <= 32'hFFFF_FFFF;
		ws <= 32'hFFFF_FFFF;
		repeat (3) @(posedge clk);
		#1;
		chk("breq", 32'hFFFF_FFFC, breq);
		chk("sreq", 32'h5A5A_FFFC, sreq);
		chk("msk", 32'h0000_0003, msk);
		chk("men", 32'h0000_0001, {31'h0, men});
		// all masked: only the trigger may raise a burst request
		xfer(1'b1, 12'h020, 32'hFFFF_FFFF);
		xfer(1'b1, 12'h014, 32'h8000_0104);
		#1;
		chk("trig", 32'h8000_0104, breq);
		@(posedge clk);
		#1;
		chk("trig", 32'h0000_0000, breq);
		@(posedge clk);
		drop <= 32'h0000_0001;
		rais <= 32'h0000_0010;
		off <= 32'h0000_0004;
		@(posedge clk);
		drop <= 32'h0;
		rais <= 32'h0;
		off <= 32'h0;
		#1;
		chk("bon", 32'hA5A5_0010, bon);
		chk("chon", 32'hFFFF_FFFB, con);
		// clock enable low: a write must leave every state alone
		ce <= 1'b0;
		xfer(1'b1, 12'h02C, 32'h0000_0008);
		ce <= 1'b1;
		#1;
		chk("ce hold", 32'hFFFF_FFFB, con);
		xfer(1'b1, 12'h02C, 32'h0000_0008);
		rchk("chon", 12'h028, 32'hFFFF_FFF3);
		xfer(1'b1, 12'h040, 32'hFFFF_FFFF);
		chk("slverr", 32'h1, {31'h0, rerr});
		xfer(1'b1, 12'h004, 32'h0000_0000);
		xfer(1'b1, 12'h024, 32'hFFFF_FFFF);
		repeat (2) @(posedge clk);
		#1;
		chk("breq", 32'h0000_0000, breq);
		chk("men", 32'h0000_0000, {31'h0, men});
		close_out;
	end
endmodule

bind dcrc_top dcrc_checker u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .i_periph_single_req(i_periph_single_req),
	.i_burst_drop_evt(i_burst_drop_evt), .i_burst_raise_evt(i_burst_raise_evt),
	.o_burst_req(o_burst_req), .o_single_req(o_single_req), .o_master_en(o_master_en),
	.o_chan_on(o_chan_on), .o_burst_only(o_burst_only), .o_req_mask(o_req_mask));

`default_nettype wire
